/* hdl/cev_comparator_control.sv */
// comparator event control: status/control register, edge events, pin drive
// ------------------------------------------------------------------
// Functional notes
// RQ1 - enable bit 7 switches comparator on
// RQ2 - bit 6 picks external pin or bandgap
// RQ3 - bit 5 flag set by event, write-one clears
// RQ4 - bit 4 gates flag onto interrupt request
// RQ5 - bit 3 reads live output, zero if disabled
// RQ6 - bit 2 drives output pin while enabled
// RQ7 - edge codes: 00/10 fall, 01 rise, 11 both
// RQ8 - output high when noninverting input larger
// RQ9 - keeps running in wait, interrupt wakes
// RQ10 - keeps running in stop, event wakes
// RQ11 - reset out of stop clears all state
// RQ12 - debug halt does not suspend comparator
// RQ13 - two-stage sync before edge detection
// RQ14 - reset clears control bits and flag
// ------------------------------------------------------------------
`timescale 1ns/1ps
module cev_comparator_control (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog core
    input  wire logic        comparator_raw,
    output logic             comparator_on,
    output logic             reference_select,
    // pin and interrupt
    output logic             comparator_output_pin_o,
    output logic             comparator_output_pin_oe,
    output logic             compare_irq
);
    import cev_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        enable;
        logic        refsel;
        logic        flag;
        logic        irq_en;
        logic        pin_en;
        logic [1:0]  edge_sel;
        logic        out_prev;
        logic        out_valid;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        pin_o;
        logic        pin_oe;
        logic        irq;
    } cev_state_t;

    cev_state_t state_reg;
    cev_state_t state_next;

    logic       out_sync;
    logic       out_live;
    logic       rise;
    logic       fall;
    logic       event_hit;
    logic       setup;
    logic       hit_reg;
    logic       do_write;
    logic [7:0] ctrl_view;

    // ------------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------------
    // polarity: core output is high when noninverting exceeds inverting
    cev_sync u_sync (                         // see RQ13 see RQ8
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (comparator_raw),
        .sync_out (out_sync)
    );

    // ------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------
    // disabled comparator reads as low and produces no edges
    assign out_live = state_reg.enable & out_sync;              // see RQ5
    assign rise     = state_reg.out_valid & out_live & ~state_reg.out_prev;
    // switching the comparator off is not a falling edge
    assign fall     = state_reg.out_valid & state_reg.enable & ~out_live
                      & state_reg.out_prev;

    always_comb begin
        case (state_reg.edge_sel)                               // see RQ7
            CEV_EDGE_FALL0: event_hit = fall;
            CEV_EDGE_RISE:  event_hit = rise;
            CEV_EDGE_FALL2: event_hit = fall;
            CEV_EDGE_BOTH:  event_hit = rise | fall;
            default:        event_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // register view and decode
    // ------------------------------------------------------------------
    assign ctrl_view = {state_reg.enable, state_reg.refsel, state_reg.flag,
                        state_reg.irq_en, out_live, state_reg.pin_en,
                        state_reg.edge_sel};
    assign setup    = psel & ~penable;
    assign hit_reg  = (paddr == CEV_STATUS_CONTROL_ADDR);
    // write acts at the access edge, while pready is high
    assign do_write = psel & penable & state_reg.ready & pwrite & hit_reg
                      & pstrb[0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // no wait, stop or debug input: logic never suspends in those modes
    always_comb begin                                  // see RQ9 see RQ10
        state_next           = state_reg;                       // see RQ12
        state_next.out_prev  = out_live;
        state_next.out_valid = state_reg.enable;
        state_next.ready     = setup;
        state_next.slverr    = setup & ~hit_reg;
        state_next.rdata     = CEV_UNMAPPED_RDATA;
        if (setup && !pwrite && hit_reg) begin
            state_next.rdata = {24'h000000, ctrl_view};
        end
        if (do_write) begin
            state_next.enable   = pwdata[CEV_BIT_ENABLE];       // see RQ1
            state_next.refsel   = pwdata[CEV_BIT_REFSEL];       // see RQ2
            state_next.irq_en   = pwdata[CEV_BIT_IRQ_EN];
            state_next.pin_en   = pwdata[CEV_BIT_PIN_EN];
            state_next.edge_sel = pwdata[CEV_EDGE_MSB:CEV_EDGE_LSB];
            if (pwdata[CEV_BIT_FLAG]) begin
                state_next.flag = 1'b0;                         // see RQ3
            end
        end
        // set wins over a simultaneous clear
        if (event_hit) begin
            state_next.flag = 1'b1;                             // see RQ3
        end
        state_next.irq    = state_next.flag & state_next.irq_en; // see RQ4
        state_next.pin_oe = state_next.enable & state_next.pin_en; // see RQ6
        state_next.pin_o  = state_next.pin_oe & out_live;       // see RQ6
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;                          // see RQ14 see RQ11
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata                   = state_reg.rdata;
    assign pready                   = state_reg.ready;
    assign pslverr                  = state_reg.slverr;
    assign comparator_on            = state_reg.enable;         // see RQ1
    assign reference_select         = state_reg.refsel;         // see RQ2
    assign comparator_output_pin_o  = state_reg.pin_o;
    assign comparator_output_pin_oe = state_reg.pin_oe;
    assign compare_irq              = state_reg.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_irq_follows_flag: assert property ( // see RQ4
        compare_irq == (state_reg.flag && state_reg.irq_en))
        else $error("interrupt does not follow flag and enable");

    chk_flag_set_event: assert property ( // see RQ3
        event_hit |=> state_reg.flag)
        else $error("event did not set flag");

    chk_flag_hold: assert property ( // see RQ3
        (state_reg.flag && !(do_write && pwdata[CEV_BIT_FLAG]))
        |=> state_reg.flag)
        else $error("flag cleared without write of one");

    chk_flag_noset: assert property ( // see RQ3
        (!state_reg.flag && !event_hit) |=> !state_reg.flag)
        else $error("flag set without event");

    chk_out_zero_off: assert property ( // see RQ5
        !state_reg.enable |-> !out_live)
        else $error("output state nonzero while disabled");

    chk_pin_enable: assert property ( // see RQ6
        comparator_output_pin_oe |-> comparator_on)
        else $error("pin driven while comparator off");

    chk_rise_mode: assert property ( // see RQ7
        (state_reg.edge_sel == CEV_EDGE_RISE && fall && !state_reg.flag
         && !rise) |=> !state_reg.flag)
        else $error("falling edge set flag in rising mode");

    chk_sync_delay: assert property ( // see RQ13
        (state_reg.enable && $stable(comparator_raw)) [*3]
        |-> out_live == comparator_raw)
        else $error("synchronised output wrong after two stages");

    chk_ready_one: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not a single cycle");

    // ------------------------------------------------------------------
    // assertions: register bus accesses
    // ------------------------------------------------------------------
    chk_enable_write: assert property ( // see RQ1
        (psel && penable && pready && pwrite && pstrb[0] && hit_reg)
        |=> comparator_on == $past(pwdata[CEV_BIT_ENABLE]))
        else $error("enable bit not taken from write");

    chk_refsel_write: assert property ( // see RQ2
        (psel && penable && pready && pwrite && pstrb[0] && hit_reg)
        |=> reference_select == $past(pwdata[CEV_BIT_REFSEL]))
        else $error("reference select not taken from write");

    chk_unmapped_err: assert property (
        (psel && !penable && !hit_reg) |=> (pready && pslverr))
        else $error("unmapped access without error");

    chk_unmapped_nowr: assert property (
        (psel && penable && pready && pwrite && !hit_reg)
        |=> ($stable(comparator_on) && $stable(reference_select)))
        else $error("unmapped write changed control");

    chk_write_rdata: assert property (
        (psel && !penable && pwrite) |=> prdata == CEV_UNMAPPED_RDATA)
        else $error("write returned nonzero read data");

    // ------------------------------------------------------------------
    // assertions: flag, edges and interrupt
    // ------------------------------------------------------------------
    chk_flag_clear: assert property ( // see RQ3
        (state_reg.flag && do_write && pwdata[CEV_BIT_FLAG] && !event_hit)
        |=> !state_reg.flag)
        else $error("write of one did not clear flag");

    chk_fall_sets: assert property ( // see RQ7
        (state_reg.edge_sel != CEV_EDGE_RISE && fall) |=> state_reg.flag)
        else $error("falling edge missed in falling mode");

    chk_rise_sets: assert property ( // see RQ7
        (state_reg.edge_sel[0] && rise) |=> state_reg.flag)
        else $error("rising edge missed in rising mode");

    chk_no_edge_off: assert property ( // see RQ1
        !state_reg.enable |-> !event_hit)
        else $error("event counted while comparator off");

    chk_irq_masked: assert property ( // see RQ4
        !state_reg.irq_en |-> !compare_irq)
        else $error("interrupt raised while masked");

    // ------------------------------------------------------------------
    // assertions: output state, pin and reset
    // ------------------------------------------------------------------
    chk_rd_outstate: assert property ( // see RQ5
        (psel && !penable && !pwrite && hit_reg)
        |=> prdata[CEV_BIT_OUTSTATE] == $past(out_live))
        else $error("read output state not the live output");

    chk_rd_disabled: assert property ( // see RQ5
        (pready && !pslverr && !prdata[CEV_BIT_ENABLE])
        |-> !prdata[CEV_BIT_OUTSTATE])
        else $error("output state read nonzero while disabled");

    chk_pin_follows: assert property ( // see RQ6
        comparator_output_pin_oe
        |-> comparator_output_pin_o == $past(out_live))
        else $error("pin does not follow comparator output");

    chk_pin_released: assert property ( // see RQ6
        !comparator_output_pin_oe |-> !comparator_output_pin_o)
        else $error("pin value shown while released");

    chk_reset_clears: assert property ( // see RQ14
        disable iff (1'b0) (!presetn ##1 !presetn) |->
        (!comparator_on && !compare_irq && !comparator_output_pin_oe))
        else $error("outputs not cleared in reset");

    // ------------------------------------------------------------------
    // cover
    // ------------------------------------------------------------------
    cov_rise_event: cover property (rise && event_hit);
    cov_fall_event: cover property (fall && event_hit);
    cov_irq: cover property (compare_irq);
    cov_set_clear: cover property (event_hit && do_write && pwdata[CEV_BIT_FLAG]);

endmodule : cev_comparator_control

/* hdl/cev_pkg.sv */
// package: register map, field positions and reset values of the comparator control
package cev_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CEV_STATUS_CONTROL_ADDR = 12'h000;
    localparam logic [31:0] CEV_UNMAPPED_RDATA      = 32'h00000000;
    localparam logic [7:0]  CEV_CTRL_RESET          = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CEV_BIT_ENABLE   = 7;
    localparam int CEV_BIT_REFSEL   = 6;
    localparam int CEV_BIT_FLAG     = 5;
    localparam int CEV_BIT_IRQ_EN   = 4;
    localparam int CEV_BIT_OUTSTATE = 3;
    localparam int CEV_BIT_PIN_EN   = 2;
    localparam int CEV_EDGE_MSB     = 1;
    localparam int CEV_EDGE_LSB     = 0;

    // ------------------------------------------------------------------
    // edge select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CEV_EDGE_FALL0 = 2'h0;
    localparam logic [1:0] CEV_EDGE_RISE  = 2'h1;
    localparam logic [1:0] CEV_EDGE_FALL2 = 2'h2;
    localparam logic [1:0] CEV_EDGE_BOTH  = 2'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CEV_SYNC_STAGES = 2;

endpackage : cev_pkg

/* hdl/cev_sync.sv */
// two-stage level synchroniser for the comparator output
`timescale 1ns/1ps
module cev_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    import cev_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
    } cev_sync_state_t;

    cev_sync_state_t state_reg;
    cev_sync_state_t state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.meta = async_in;
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.sync;

endmodule : cev_sync

/* verification/cev_analog_model.sv */
// model of the analog comparator core and its input pins
`timescale 1ns/1ps
module cev_analog_model (
    // control from the block
    input  wire logic        comparator_on,
    input  wire logic        reference_select,
    // analog levels in millivolts
    input  wire logic [11:0] noninverting_mv,
    input  wire logic [11:0] inverting_mv,
    input  wire logic [11:0] bandgap_mv,
    // output to the block
    output logic             comparator_raw
);
    logic [11:0] plus_mv;

    assign plus_mv = reference_select ? bandgap_mv : noninverting_mv;
    // core held low while switched off
    assign comparator_raw = comparator_on && (plus_mv > inverting_mv);
endmodule : cev_analog_model

/* verification/cev_comparator_control_tb.sv */
// self-checking bench for the comparator event control
`timescale 1ns/1ps
module cev_comparator_control_tb;
    import cev_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, raw;
    logic [11:0] paddr, vp, vm, vb;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, on, rsel, pin_o, pin_oe, irq;
    int          n_fail, check_count;
    logic [31:0] q;
    logic        e;
    logic [1:0]  c;

    cev_comparator_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_raw(raw), .comparator_on(on), .reference_select(rsel),
        .comparator_output_pin_o(pin_o), .comparator_output_pin_oe(pin_oe),
        .compare_irq(irq));
    cev_analog_model core (.comparator_on(on), .reference_select(rsel),
        .noninverting_mv(vp), .inverting_mv(vm), .bandgap_mv(vb),
        .comparator_raw(raw));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task results;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q       = prdata;
        e       = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            results();
        end
    endtask : xfer

    task wr(input logic [7:0] v);
        xfer(1'b1, CEV_STATUS_CONTROL_ADDR, {24'h0, v});
    endtask : wr

    task rd_chk(input logic [7:0] v, input string nm);
        xfer(1'b0, CEV_STATUS_CONTROL_ADDR, 32'h0);
        chk(nm, q, {24'h0, v});
    endtask : rd_chk

    task settle;
        repeat (6) @(posedge pclk);
    endtask : settle

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        vp = 12'h064;
        vm = 12'h1F4;
        vb = 12'h12C;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h00, "reset ctrl");
        chk("reset oe", {31'h0, pin_oe}, 32'h0);
        $display("test reset done");
        wr(8'h91);
        vp <= 12'h2BC;
        settle();
        rd_chk(8'hB9, "flag on rise");
        chk("irq set", {31'h0, irq}, 32'h1);
        chk("core on", {31'h0, on}, 32'h1);
        wr(8'hB1);
        settle();
        rd_chk(8'h99, "flag cleared");
        chk("irq clear", {31'h0, irq}, 32'h0);
        $display("test flag done");
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(8'hA0 | {6'h0, c});
            vp <= 12'h064;
            settle();
            rd_chk(8'h80 | {6'h0, c} | {2'h0, c != 2'h1, 5'h0}, "fall");
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr(8'hA0 | {6'h0, c});
            vp <= 12'h2BC;
            settle();
            rd_chk(8'h88 | {6'h0, c} | {2'h0, c[0], 5'h0}, "rise");
        end
        $display("test edge codes done");
        wr(8'hE0);
        settle();
        rd_chk(8'hE0, "bandgap low");
        chk("refsel port", {31'h0, rsel}, 32'h1);
        vb <= 12'h320;
        settle();
        rd_chk(8'hE8, "bandgap high");
        $display("test reference done");
        wr(8'hA4);
        settle();
        chk("pin oe", {31'h0, pin_oe}, 32'h1);
        chk("pin high", {31'h0, pin_o}, 32'h1);
        vp <= 12'h064;
        settle();
        chk("pin low", {31'h0, pin_o}, 32'h0);
        rd_chk(8'hA4, "pin fall flag");
        wr(8'h24);
        vp <= 12'h2BC;
        settle();
        rd_chk(8'h04, "disabled");
        chk("pin off", {31'h0, pin_oe}, 32'h0);
        xfer(1'b0, 12'h010, 32'h0);
        chk("unmapped data", q, CEV_UNMAPPED_RDATA);
        chk("unmapped err", {31'h0, e}, 32'h1);
        xfer(1'b1, 12'h010, 32'h000000FF);
        chk("unmapped wr err", {31'h0, e}, 32'h1);
        rd_chk(8'h04, "unmapped wr ignored");
        $display("test pin and map done");
        wr(8'h94);
        settle();
        vp <= 12'h064;
        settle();
        chk("irq pre reset", {31'h0, irq}, 32'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h00, "mid reset");
        chk("irq after reset", {31'h0, irq}, 32'h0);
        $display("test reset mid-run done");
        results();
    end
endmodule : cev_comparator_control_tb
